//--- verilog/terminal_cmd_pkg.sv
// constants and types shared by the terminal run command logic
package terminal_cmd_pkg;

   // ----------------------------------------------------------------------
   // clock and time bases
   // ----------------------------------------------------------------------
   localparam int CLK_HZ        = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_TIME_NS    = 1_000_000;
   localparam int TICK10_TIME_NS = 10_000_000;
   localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int TICK10_CYCLES = TICK10_TIME_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // terminal positions in the filtered vector
   // ----------------------------------------------------------------------
   localparam int N_TERM     = 12;
   localparam int T_FWD      = 0;
   localparam int T_REV      = 1;
   localparam int T_ENA      = 2;
   localparam int T_UP       = 3;
   localparam int T_DOWN     = 4;
   localparam int T_RAMP1    = 5;
   localparam int T_RAMP2    = 6;
   localparam int T_MOTOR    = 7;
   localparam int T_STEP_LSB = 8;

   // ----------------------------------------------------------------------
   // settings: limits and default values (units in the comments beside them)
   // ----------------------------------------------------------------------
   localparam logic [9:0]  FILTER_MS_MAX     = 10'h3E8;   // 1.000 s
   localparam logic [9:0]  FILTER_MS_DEFAULT = 10'h00A;   // 0.010 s
   localparam logic [15:0] UPDOWN_RATE_DEFAULT = 16'h03E8; // 1.00 Hz/s
   localparam logic [11:0] AI_FULL_SCALE     = 12'h3E8;   // 10.00 V
   localparam logic [9:0]  AI_FILTER_MAX     = 10'h3E8;   // 10.00 s
   localparam logic [9:0]  AI_FILTER_DEFAULT = 10'h00A;   // 0.10 s
   localparam logic [10:0] STEP_FULL         = 11'h3E8;   // 100.0 %
   localparam logic [26:0] RATE_WRAP         = 27'h2FAF080; // CLK_HZ
   localparam logic [9:0]  CNT_RESET         = 10'h000;

   typedef enum logic [1:0] {
      MODE_TWO_WIRE_1   = 2'b00,
      MODE_TWO_WIRE_2   = 2'b01,
      MODE_THREE_WIRE_1 = 2'b10,
      MODE_THREE_WIRE_2 = 2'b11
   } ctrl_mode_t;

endpackage : terminal_cmd_pkg

//--- verilog/terminal_run_command_logic.sv
// terminal filtering, run command decode, set selection, up/down, analog
`timescale 1ns/1ps
// How it works
// - step entry 100.0% equals the configured maximum output frequency.
// - two ramp terminals pick acceleration/deceleration set one to four.
// - motor terminal off selects motor group one, on selects group two.
// - digital terminals filtered by 0 to 1.000 s setting, default 0.010 s.
// - mode setting 0..3 picks two-wire 1/2 or three-wire 1/2.
// - two-wire 2: forward enables run, reverse input sets direction.
// - three-wire 1: forward or reverse rising edge starts run while enabled.
// - three-wire 1: opening the closed enable contact stops the drive.
// - three-wire 2: forward edge starts, reverse level directs, enable stops.
// - two-wire: after an outside stop, run needs input released and reapplied.
// - up/down terminals ramp set frequency at 0.001..65.535 Hz/s rate.
// - analog input above maximum point counts as the maximum point.
// - analog below minimum point gives minimum setting or zero percent.
// - in current mode one milliampere counts as half a volt.
// - analog input smoothed by 0 to 10.00 s filter, default 0.10 s.
// - below-minimum select 0 gives minimum setting, 1 gives zero.
module terminal_run_command_logic #(
   parameter int MS_CYCLES     = terminal_cmd_pkg::MS_CYCLES,
   parameter int TICK10_CYCLES = terminal_cmd_pkg::TICK10_CYCLES
) (
   input  wire logic               CLOCK,
   input  wire logic               RST,
   input  wire logic               FORWARD_RUN_INPUT,
   input  wire logic               REVERSE_DIR_INPUT,
   input  wire logic               ENABLE_NC_INPUT,
   input  wire logic               UP_INPUT,
   input  wire logic               DOWN_INPUT,
   input  wire logic               RAMP_SEL1_INPUT,
   input  wire logic               RAMP_SEL2_INPUT,
   input  wire logic               MOTOR_SEL_INPUT,
   input  wire logic [3:0]         STEP_SEL_INPUT,
   input  wire logic               OTHER_STOP,
   input  wire logic [9:0]         INPUT_FILTER_TIME,
   input  wire logic [1:0]         TERMINAL_CONTROL_MODE_SEL,
   input  wire logic [15:0]        UPDOWN_CHANGE_RATE,
   input  wire logic [15:0]        MAX_OUTPUT_FREQUENCY,
   input  wire logic               STEP_TABLE_WR,
   input  wire logic [3:0]         STEP_TABLE_IDX,
   input  wire logic [10:0]        STEP_TABLE_DATA,
   input  wire logic [11:0]        ANALOG_INPUT_ONE,
   input  wire logic               ANALOG_CURRENT_MODE,
   input  wire logic [11:0]        ANALOG_MIN_POINT,
   input  wire logic [11:0]        ANALOG_MAX_POINT,
   input  wire logic signed [14:0] ANALOG_MIN_SETTING,
   input  wire logic signed [14:0] ANALOG_MAX_SETTING,
   input  wire logic               BELOW_MIN_SELECT,
   input  wire logic [9:0]         ANALOG_FILTER_TIME,
   output logic                    RUN_CMD,
   output logic                    REVERSE_CMD,
   output logic [1:0]              RAMP_SET,
   output logic                    MOTOR_SET,
   output logic [23:0]             UPDOWN_FREQ,
   output logic [15:0]             STEP_FREQ,
   output logic signed [15:0]      ANALOG_PERCENT
);

   // ----------------------------------------------------------------------
   // time bases
   // ----------------------------------------------------------------------
   logic [15:0] ms_cnt_q;
   logic        ms_tick_q;
   logic [19:0] t10_cnt_q;
   logic        t10_tick_q;

   always_ff @(posedge CLOCK)
   begin
      if (RST || ms_cnt_q == 16'(MS_CYCLES - 1))
         ms_cnt_q <= 16'h0000;
      else
         ms_cnt_q <= ms_cnt_q + 16'h0001;
      ms_tick_q <= !RST && ms_cnt_q == 16'(MS_CYCLES - 1);
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST || t10_cnt_q == 20'(TICK10_CYCLES - 1))
         t10_cnt_q <= 20'h00000;
      else
         t10_cnt_q <= t10_cnt_q + 20'h00001;
      t10_tick_q <= !RST && t10_cnt_q == 20'(TICK10_CYCLES - 1);
   end

   // ----------------------------------------------------------------------
   // terminal synchronisers and filters
   // ----------------------------------------------------------------------
   logic [terminal_cmd_pkg::N_TERM-1:0] raw_w;
   logic [terminal_cmd_pkg::N_TERM-1:0] sync1_q;
   logic [terminal_cmd_pkg::N_TERM-1:0] sync2_q;
   logic [terminal_cmd_pkg::N_TERM-1:0] filt_q;
   logic [9:0]                          cnt_q [terminal_cmd_pkg::N_TERM];
   logic [9:0]                          filt_lim;

   assign raw_w = {STEP_SEL_INPUT, MOTOR_SEL_INPUT, RAMP_SEL2_INPUT,
                   RAMP_SEL1_INPUT, DOWN_INPUT, UP_INPUT, ENABLE_NC_INPUT,
                   REVERSE_DIR_INPUT, FORWARD_RUN_INPUT};
   // settings past one second are held at one second
   assign filt_lim = (INPUT_FILTER_TIME > terminal_cmd_pkg::FILTER_MS_MAX) ?
                     terminal_cmd_pkg::FILTER_MS_MAX : INPUT_FILTER_TIME;

   always_ff @(posedge CLOCK)
   begin
      sync1_q <= RST ? '0 : raw_w;
      sync2_q <= RST ? '0 : sync1_q;
   end

   genvar gi;
   generate
      for (gi = 0; gi < terminal_cmd_pkg::N_TERM; gi++)
      begin : g_filt
         always_ff @(posedge CLOCK)
         begin
            if (RST)
            begin
               filt_q[gi] <= 1'b0;
               cnt_q[gi]  <= terminal_cmd_pkg::CNT_RESET;
            end
            else if (sync2_q[gi] == filt_q[gi])
               cnt_q[gi] <= terminal_cmd_pkg::CNT_RESET;
            else if (cnt_q[gi] >= filt_lim)
            begin
               filt_q[gi] <= sync2_q[gi];
               cnt_q[gi]  <= terminal_cmd_pkg::CNT_RESET;
            end
            else if (ms_tick_q)
               cnt_q[gi] <= cnt_q[gi] + 10'h001;
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // run command decode
   // ----------------------------------------------------------------------
   terminal_cmd_pkg::ctrl_mode_t mode;
   logic forward_run_input;
   logic reverse_dir_input;
   logic ena;
   logic fwd_prev_q;
   logic rev_prev_q;
   logic fwd_rise;
   logic rev_rise;
   logic two_wire;
   logic demand;
   logic demand_rev;
   logic lock_q;
   logic run3_q;
   logic dir3_q;

   assign mode     = terminal_cmd_pkg::ctrl_mode_t'(TERMINAL_CONTROL_MODE_SEL);
   assign forward_run_input      = filt_q[terminal_cmd_pkg::T_FWD];
   assign reverse_dir_input      = filt_q[terminal_cmd_pkg::T_REV];
   assign ena      = filt_q[terminal_cmd_pkg::T_ENA];
   assign fwd_rise = forward_run_input && !fwd_prev_q;
   assign rev_rise = reverse_dir_input && !rev_prev_q;
   assign two_wire = !TERMINAL_CONTROL_MODE_SEL[1];

   always_comb
   begin
      unique case (mode)
         terminal_cmd_pkg::MODE_TWO_WIRE_1:
         begin
            demand     = forward_run_input ^ reverse_dir_input;
            demand_rev = reverse_dir_input;
         end
         terminal_cmd_pkg::MODE_TWO_WIRE_2:
         begin
            demand     = forward_run_input;
            demand_rev = reverse_dir_input;
         end
         terminal_cmd_pkg::MODE_THREE_WIRE_1,
         terminal_cmd_pkg::MODE_THREE_WIRE_2:
         begin
            demand     = run3_q;
            demand_rev = dir3_q;
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      fwd_prev_q <= RST ? 1'b0 : forward_run_input;
      rev_prev_q <= RST ? 1'b0 : reverse_dir_input;
   end

   // an outside stop latches until the two-wire demand falls away
   always_ff @(posedge CLOCK)
   begin
      if (RST || !two_wire)
         lock_q <= 1'b0;
      else if (OTHER_STOP)
         lock_q <= demand;
      else if (!demand)
         lock_q <= 1'b0;
   end

   // direction is cleared too, so a three-wire start after reset is not unknown
   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         run3_q <= 1'b0;
         dir3_q <= 1'b0;
      end
      else if (two_wire || !ena || OTHER_STOP)
         run3_q <= 1'b0;
      else if (mode == terminal_cmd_pkg::MODE_THREE_WIRE_1)
      begin
         if (fwd_rise)
         begin
            run3_q <= 1'b1;
            dir3_q <= 1'b0;
         end
         else if (rev_rise)
         begin
            run3_q <= 1'b1;
            dir3_q <= 1'b1;
         end
      end
      else
      begin
         if (fwd_rise)
            run3_q <= 1'b1;
         dir3_q <= reverse_dir_input;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
      begin
         RUN_CMD     <= 1'b0;
         REVERSE_CMD <= 1'b0;
      end
      else
      begin
         RUN_CMD     <= demand && !lock_q && !OTHER_STOP;
         REVERSE_CMD <= demand_rev;
      end
   end

   // ----------------------------------------------------------------------
   // set selection
   // ----------------------------------------------------------------------
   always_ff @(posedge CLOCK)
   begin
      RAMP_SET  <= RST ? 2'h0 : {filt_q[terminal_cmd_pkg::T_RAMP2],
                                 filt_q[terminal_cmd_pkg::T_RAMP1]};
      MOTOR_SET <= RST ? 1'b0 : filt_q[terminal_cmd_pkg::T_MOTOR];
   end

   // ----------------------------------------------------------------------
   // multi-step reference, units 0.1 % of maximum frequency
   // ----------------------------------------------------------------------
   logic [10:0] step_mem [16];
   logic [10:0] step_val;
   logic [26:0] step_prod;

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         step_mem <= '{default: 11'h000};
      else if (STEP_TABLE_WR)
         step_mem[STEP_TABLE_IDX] <= (STEP_TABLE_DATA > terminal_cmd_pkg::
            STEP_FULL) ? terminal_cmd_pkg::STEP_FULL : STEP_TABLE_DATA;
   end

   assign step_val  = step_mem[filt_q[terminal_cmd_pkg::T_STEP_LSB +: 4]];
   assign step_prod = 27'(step_val) * 27'(MAX_OUTPUT_FREQUENCY);

   always_ff @(posedge CLOCK)
   begin
      STEP_FREQ <= RST ? 16'h0000 :
         16'(step_prod / 27'(terminal_cmd_pkg::STEP_FULL));
   end

   // ----------------------------------------------------------------------
   // up/down ramp: one millihertz per wrap of the rate accumulator
   // ----------------------------------------------------------------------
   logic        up_only;
   logic        down_only;
   logic [26:0] rate_acc_q;
   logic [26:0] rate_sum;
   logic        ud_step;
   logic [23:0] freq_lim;

   assign up_only   = filt_q[terminal_cmd_pkg::T_UP] &&
                      !filt_q[terminal_cmd_pkg::T_DOWN];
   assign down_only = filt_q[terminal_cmd_pkg::T_DOWN] &&
                      !filt_q[terminal_cmd_pkg::T_UP];
   assign rate_sum  = rate_acc_q + 27'(UPDOWN_CHANGE_RATE);
   assign ud_step   = rate_sum >= terminal_cmd_pkg::RATE_WRAP;
   assign freq_lim  = 24'(MAX_OUTPUT_FREQUENCY) * 24'h00000A;

   always_ff @(posedge CLOCK)
   begin
      if (RST || !(up_only || down_only))
         rate_acc_q <= 27'h0000000;
      else if (ud_step)
         rate_acc_q <= rate_sum - terminal_cmd_pkg::RATE_WRAP;
      else
         rate_acc_q <= rate_sum;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         UPDOWN_FREQ <= 24'h000000;
      else if (UPDOWN_FREQ > freq_lim)
         UPDOWN_FREQ <= freq_lim;
      else if (ud_step && up_only && UPDOWN_FREQ < freq_lim)
         UPDOWN_FREQ <= UPDOWN_FREQ + 24'h000001;
      else if (ud_step && down_only && UPDOWN_FREQ != 24'h000000)
         UPDOWN_FREQ <= UPDOWN_FREQ - 24'h000001;
   end

   // ----------------------------------------------------------------------
   // analog input one: scale, clip, smooth, curve
   // ----------------------------------------------------------------------
   logic [11:0]        ai_volt;
   logic [11:0]        ai_clip;
   logic [11:0]        ai_filt_q;
   logic signed [12:0] ai_diff;
   logic signed [12:0] ai_stepv;
   logic [9:0]         ai_ftime;
   logic signed [31:0] ai_num;
   logic signed [15:0] ai_curve;

   // current samples are in 0.01 mA, so halving yields 0.01 V
   assign ai_volt  = ANALOG_CURRENT_MODE ? {1'b0, ANALOG_INPUT_ONE[11:1]}
                                         : ANALOG_INPUT_ONE;
   assign ai_clip  = (ai_volt > ANALOG_MAX_POINT) ? ANALOG_MAX_POINT
                                                  : ai_volt;
   assign ai_ftime = (ANALOG_FILTER_TIME > terminal_cmd_pkg::AI_FILTER_MAX) ?
                     terminal_cmd_pkg::AI_FILTER_MAX : ANALOG_FILTER_TIME;
   assign ai_diff  = $signed({1'b0, ai_clip}) - $signed({1'b0, ai_filt_q});

   // step of diff/time, never zero while apart, so the output settles
   always_comb
   begin
      ai_stepv = ai_diff / $signed({3'b000, ai_ftime});
      if (ai_stepv == 13'sh0000 && ai_diff != 13'sh0000)
         ai_stepv = ai_diff[12] ? -13'sh0001 : 13'sh0001;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RST)
         ai_filt_q <= 12'h000;
      else if (ai_ftime == 10'h000)
         ai_filt_q <= ai_clip;
      else if (t10_tick_q)
         ai_filt_q <= 12'(ai_filt_q + 12'(ai_stepv));
   end

   always_comb
   begin
      // kept signed throughout so falling curves divide correctly
      ai_num = $signed(32'(ai_filt_q - ANALOG_MIN_POINT)) *
               (32'(ANALOG_MAX_SETTING) - 32'(ANALOG_MIN_SETTING));
      if (ai_filt_q < ANALOG_MIN_POINT)
         ai_curve = BELOW_MIN_SELECT ? 16'sh0000
                                     : 16'(ANALOG_MIN_SETTING);
      else if (ANALOG_MAX_POINT <= ANALOG_MIN_POINT)
         ai_curve = 16'(ANALOG_MAX_SETTING);
      else
         ai_curve = 16'(32'(ANALOG_MIN_SETTING) + ai_num /
                    $signed(32'(ANALOG_MAX_POINT - ANALOG_MIN_POINT)));
   end

   always_ff @(posedge CLOCK)
   begin
      ANALOG_PERCENT <= RST ? 16'sh0000 : ai_curve;
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   sequence s_fwd_edge_enabled;
      fwd_rise && ena && !OTHER_STOP;
   endsequence
   sequence s_run_forward;
      run3_q && !dir3_q;
   endsequence

   property p_ramp_sel;
      ##1 RAMP_SET == {$past(filt_q[terminal_cmd_pkg::T_RAMP2]),
                       $past(filt_q[terminal_cmd_pkg::T_RAMP1])};
   endproperty
   a_ramp_sel: assert property (p_ramp_sel)
      else $error("ramp set does not follow terminals");

   property p_motor_sel;
      $rose(filt_q[terminal_cmd_pkg::T_MOTOR]) |=> MOTOR_SET;
   endproperty
   a_motor_sel: assert property (p_motor_sel)
      else $error("motor set did not follow terminal");

   property p_filter_hold;
      $changed(filt_q[0]) |-> $past(cnt_q[0]) >= $past(filt_lim);
   endproperty
   a_filter_hold: assert property (p_filter_hold)
      else $error("terminal changed before filter time");

   property p_two_wire_1;
      mode == terminal_cmd_pkg::MODE_TWO_WIRE_1 && forward_run_input && reverse_dir_input
         |=> !RUN_CMD;
   endproperty
   a_two_wire_1: assert property (p_two_wire_1)
      else $error("two-wire 1 ran with both inputs on");

   property p_two_wire_2;
      mode == terminal_cmd_pkg::MODE_TWO_WIRE_2 && !forward_run_input |=> !RUN_CMD;
   endproperty
   a_two_wire_2: assert property (p_two_wire_2)
      else $error("two-wire 2 ran without forward enable");

   property p_three_start;
      (mode == terminal_cmd_pkg::MODE_THREE_WIRE_1) and s_fwd_edge_enabled
         |=> s_run_forward ##1 RUN_CMD && !REVERSE_CMD;
   endproperty
   a_three_start: assert property (p_three_start)
      else $error("three-wire forward edge did not start");

   property p_three_stop;
      !two_wire && !ena |=> !run3_q ##1 !RUN_CMD;
   endproperty
   a_three_stop: assert property (p_three_stop)
      else $error("open enable did not stop the drive");

   property p_lockout;
      two_wire && OTHER_STOP && demand ##1 demand [*2] |-> !RUN_CMD;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("two-wire restarted without release");

   property p_updown;
      ud_step && up_only && UPDOWN_FREQ < freq_lim
         |=> UPDOWN_FREQ == $past(UPDOWN_FREQ) + 24'h000001;
   endproperty
   a_updown: assert property (p_updown)
      else $error("up step did not raise frequency");

   property p_ai_below;
      ai_filt_q < ANALOG_MIN_POINT && BELOW_MIN_SELECT
         |=> ANALOG_PERCENT == 16'sh0000;
   endproperty
   a_ai_below: assert property (p_ai_below)
      else $error("below minimum did not give zero");

   property p_ai_clip;
      ai_ftime == 10'h000 |=> ai_filt_q <= $past(ANALOG_MAX_POINT);
   endproperty
   a_ai_clip: assert property (p_ai_clip)
      else $error("analog value above maximum point");

endmodule : terminal_run_command_logic

//--- verif/contact_bank.sv
// contact bank model for the drive's digital input terminals
`timescale 1ns/1ps
module contact_bank (
   input  wire logic        clk,
   input  wire logic [11:0] closed,
   output logic [11:0]      pins
);
   // ----------------
   // contacts
   // ----------------
   // a contact settles one clock after it is thrown, never mid-cycle
   always @(posedge clk)
   begin
      pins <= closed;
   end
endmodule : contact_bank

//--- verif/tb_terminal_run_command_logic.sv
// self-checking bench for the terminal run command logic
`timescale 1ns/1ps
`define CHK(nm, e, a) \
   begin \
      compares++; \
      if ((a) !== (e)) \
      begin \
         fails++; \
         $display("CHECK FAILED %s exp %0d got %0d", nm, e, a); \
      end \
   end
module tb_terminal_run_command_logic;
   logic               clk = 0, rst = 1, ostop = 0, wr = 0, cur = 0;
   logic               bsel = 0, run, reverse_dir_input, motor;
   logic [11:0]        closed = 12'h004, ai = 12'h000;
   logic [11:0]        amin = 12'h0C8, amax = 12'h320;
   wire  [11:0]        pins;
   logic [9:0]         fms = 10'h000, afilt = 10'h000;
   logic [1:0]         mode = 2'h0, ramp;
   logic [15:0]        rate = 16'hFFFF, maxf = 16'h1388, stepf;
   logic [3:0]         idx = 4'h0;
   logic [10:0]        data = 11'h000;
   logic signed [14:0] mset = -15'sd5000, xset = 15'sd10000;
   logic signed [15:0] apct;
   logic [23:0]        udf;
   int                 fails = 0, compares = 0;
   always #10 clk = ~clk;
   contact_bank u_sw (.clk(clk), .closed(closed), .pins(pins));
   terminal_run_command_logic #(.MS_CYCLES(10), .TICK10_CYCLES(20)) u_dut (
      .CLOCK(clk), .RST(rst), .FORWARD_RUN_INPUT(pins[0]),
      .REVERSE_DIR_INPUT(pins[1]), .ENABLE_NC_INPUT(pins[2]),
      .UP_INPUT(pins[3]), .DOWN_INPUT(pins[4]), .RAMP_SEL1_INPUT(pins[5]),
      .RAMP_SEL2_INPUT(pins[6]), .MOTOR_SEL_INPUT(pins[7]),
      .STEP_SEL_INPUT(pins[11:8]), .OTHER_STOP(ostop),
      .INPUT_FILTER_TIME(fms), .TERMINAL_CONTROL_MODE_SEL(mode),
      .UPDOWN_CHANGE_RATE(rate), .MAX_OUTPUT_FREQUENCY(maxf),
      .STEP_TABLE_WR(wr), .STEP_TABLE_IDX(idx), .STEP_TABLE_DATA(data),
      .ANALOG_INPUT_ONE(ai), .ANALOG_CURRENT_MODE(cur),
      .ANALOG_MIN_POINT(amin), .ANALOG_MAX_POINT(amax),
      .ANALOG_MIN_SETTING(mset), .ANALOG_MAX_SETTING(xset),
      .BELOW_MIN_SELECT(bsel), .ANALOG_FILTER_TIME(afilt),
      .RUN_CMD(run), .REVERSE_CMD(reverse_dir_input), .RAMP_SET(ramp), .MOTOR_SET(motor),
      .UPDOWN_FREQ(udf), .STEP_FREQ(stepf), .ANALOG_PERCENT(apct));
   // ----------------
   // helpers
   // ----------------
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tk
   task automatic complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // polls, so the check does not hang on a dead run output
   task automatic exp_run(input logic r, input logic d, input logic dc);
      int i;
      compares++;
      for (i = 0; i < 20; i++)
      begin
         if (run === r && (dc || reverse_dir_input === d))
            break;
         tk(1);
      end
      if (i == 20)
      begin
         fails++;
         $display("CHECK FAILED run_dir exp %0d%0d got %0d%0d", r, d, run, reverse_dir_input);
         complete_run();
      end
   endtask : exp_run
   task automatic pulse(input int b);
      closed[b] = 1'b1;
      tk(8);
      closed[b] = 1'b0;
   endtask : pulse
   // ----------------
   // scenarios
   // ----------------
   task automatic t_sets;
      logic [2:0] i;
      for (i = 0; i < 4; i++)
      begin
         closed[5] = i[0];
         closed[6] = i[1];
         closed[7] = i[0];
         tk(10);
         `CHK("ramp_set", i[1:0], ramp)
         `CHK("motor_set", i[0], motor)
      end
   endtask : t_sets
   task automatic t_two_wire;
      logic [2:0] m, k;
      for (m = 0; m < 2; m++)
         for (k = 0; k < 4; k++)
         begin
            mode = m[1:0];
            closed[1:0] = k[1:0];
            exp_run(m[0] ? k[0] : k[0] ^ k[1], k[1], 1'b0);
         end
      closed[1:0] = 2'h0;
      tk(8);
   endtask : t_two_wire
   task automatic t_three_wire;
      mode = 2'h2;
      tk(8);
      pulse(0);
      exp_run(1'b1, 1'b0, 1'b0);
      pulse(1);
      exp_run(1'b1, 1'b1, 1'b0);
      closed[2] = 1'b0;
      exp_run(1'b0, 1'b0, 1'b1);
      closed[2] = 1'b1;
      tk(10);
      `CHK("run_after_enable", 1'b0, run)
      mode = 2'h3;
      closed[1] = 1'b1;
      tk(8);
      pulse(0);
      exp_run(1'b1, 1'b1, 1'b0);
      closed[1] = 1'b0;
      exp_run(1'b1, 1'b0, 1'b0);
      closed[2] = 1'b0;
      exp_run(1'b0, 1'b0, 1'b1);
      closed[2] = 1'b1;
   endtask : t_three_wire
   task automatic t_lock;
      mode = 2'h0;
      closed[0] = 1'b1;
      exp_run(1'b1, 1'b0, 1'b0);
      ostop = 1'b1;
      tk(1);
      ostop = 1'b0;
      tk(10);
      `CHK("run_locked", 1'b0, run)
      closed[0] = 1'b0;
      tk(8);
      closed[0] = 1'b1;
      exp_run(1'b1, 1'b0, 1'b0);
      closed[0] = 1'b0;
   endtask : t_lock
   task automatic t_filter;
      fms = 10'h003;
      closed[5] = 1'b0;
      tk(15);
      closed[5] = 1'b1;
      tk(60);
      `CHK("glitch_ramp", 2'h3, ramp)
      closed[5] = 1'b0;
      tk(20);
      `CHK("early_ramp", 2'h3, ramp)
      tk(40);
      `CHK("late_ramp", 2'h2, ramp)
      fms = 10'h000;
   endtask : t_filter
   task automatic t_step;
      wr = 1'b1;
      idx = 4'h5;
      data = 11'h3E8;
      tk(1);
      idx = 4'h6;
      data = 11'h1F4;
      tk(1);
      wr = 1'b0;
      closed[11:8] = 4'h5;
      tk(10);
      `CHK("step_full", 16'h1388, stepf)
      closed[11:8] = 4'h6;
      tk(10);
      `CHK("step_half", 16'h09C4, stepf)
   endtask : t_step
   // 2000 cycles at 65.535 Hz/s moves the setting by 2 mHz
   task automatic t_updown;
      closed[3] = 1'b1;
      tk(2000);
      closed[3] = 1'b0;
      tk(10);
      `CHK("up_freq", 24'h000002, udf)
      closed[4] = 1'b1;
      tk(2000);
      closed[4] = 1'b0;
      tk(10);
      `CHK("down_freq", 24'h000000, udf)
   endtask : t_updown
   task automatic t_analog;
      logic [11:0] va [5] = '{12'h3E8, 12'h1F4, 12'h064, 12'h064, 12'h3E8};
      logic        vc [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      logic        vb [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      int          ve [5] = '{10000, 2500, -5000, 0, 2500};
      for (int i = 0; i < 5; i++)
      begin
         ai = va[i];
         cur = vc[i];
         bsel = vb[i];
         tk(8);
         `CHK("analog_pct", 16'(ve[i]), apct)
      end
      cur = 1'b0;
      mset = 15'sd10000;
      xset = -15'sd5000;
      ai = 12'h2BC;
      tk(8);
      `CHK("analog_fall", -16'sd2500, apct)
      mset = -15'sd5000;
      xset = 15'sd10000;
      afilt = 10'h00A;
      ai = 12'h320;
      tk(10);
      `CHK("analog_slow", 1'b1, apct < 16'sd10000)
      tk(6000);
      `CHK("analog_settled", 16'sd10000, apct)
   endtask : t_analog
   // ----------------
   // main sequence
   // ----------------
   initial
   begin
      tk(5);
      rst = 1'b0;
      t_sets();
      $display("test sets done");
      t_two_wire();
      $display("test two_wire done");
      t_three_wire();
      $display("test three_wire done");
      t_lock();
      $display("test lock done");
      t_filter();
      $display("test filter done");
      t_step();
      $display("test step done");
      t_updown();
      $display("test updown done");
      t_analog();
      $display("test analog done");
      complete_run();
   end
   initial
   begin
      #2_000_000;
      fails++;
      complete_run();
   end
endmodule : tb_terminal_run_command_logic
